// File: logic/anm_defines.vh
// Register map, field positions, reset values and counts for the mode control block
`ifndef ANM_DEFINES_VH
`define ANM_DEFINES_VH

// Register indexes; the byte address is four times the index
`define ANM_IDX_BMC 5'h00
`define ANM_IDX_BMS 5'h01
`define ANM_IDX_ADV 5'h04
`define ANM_IDX_LPA 5'h05
`define ANM_IDX_PMS 5'h19

// Basic mode control fields
`define ANM_BMC_SWRST 15
`define ANM_BMC_SPD100 13
`define ANM_BMC_ANEN 12
`define ANM_BMC_RESTART 9
`define ANM_BMC_FDX 8
`define ANM_BMC_RST_VAL 16'h3000
`define ANM_BMC_WMASK 16'hb3ff

// Basic mode status fields
`define ANM_BMS_FIXED 16'h7809
`define ANM_BMS_ANDONE 5
`define ANM_BMS_LINK 2

// Advertisement register
`define ANM_ADV_DEF 16'h01e1
`define ANM_ADV_100F 8
`define ANM_ADV_100H 7
`define ANM_ADV_10F 6
`define ANM_ADV_10H 5

// Mode status fields
`define ANM_PMS_ANEN 10
`define ANM_PMS_FDX 7
`define ANM_PMS_SPD10 6

// Strap pin states
`define ANM_ST_L 2'h0
`define ANM_ST_M 2'h1
`define ANM_ST_H 2'h2
`define ANM_ST_C 2'h3

// Strap observation window in clock cycles
`define ANM_STRAP_WIN 64

// Bus responses
`define ANM_RESP_OKAY 2'h0
`define ANM_RESP_SLVERR 2'h2

`endif

// File: logic/anm_strap_decode.v
// Four-level strap classifier from two threshold comparator outputs
`timescale 1ns/1ps
`default_nettype none
`include "anm_defines.vh"

module anm_strap_decode #(
   parameter WIN = `ANM_STRAP_WIN
) (
   input wire clk,
   input wire resetn,
   input wire start,
   input wire cmp_lo,
   input wire cmp_hi,
   output reg [1:0] state_r,
   output reg done_r
);
   reg [15:0] cnt_r;
   reg busy_r;
   reg lo_d_r;
   reg hi_d_r;
   reg lo_tog_r;
   reg hi_tog_r;

   // ---------------------------------------------------------------
   // Watch both comparators over a window, then classify
   // ---------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 16'h0000;
         busy_r <= 1'b0;
         lo_d_r <= 1'b0;
         hi_d_r <= 1'b0;
         lo_tog_r <= 1'b0;
         hi_tog_r <= 1'b0;
         state_r <= `ANM_ST_M;
         done_r <= 1'b0;
      end else begin
         lo_d_r <= cmp_lo;
         hi_d_r <= cmp_hi;
         if (start && !busy_r && !done_r) begin
            busy_r <= 1'b1;
            cnt_r <= 16'h0000;
            lo_tog_r <= 1'b0;
            hi_tog_r <= 1'b0;
         end else if (busy_r) begin
            if (cnt_r != 16'h0000) begin
               if (cmp_lo != lo_d_r)
                  lo_tog_r <= 1'b1;
               if (cmp_hi != hi_d_r)
                  hi_tog_r <= 1'b1;
            end
            if (cnt_r == WIN[15:0] - 16'h0001) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
               // Both toggling is clock; a lone high-side trip reads mid
               if (lo_tog_r && hi_tog_r)
                  state_r <= `ANM_ST_C;
               else if (cmp_lo && cmp_hi)
                  state_r <= `ANM_ST_H;
               else if (!cmp_lo && !cmp_hi)
                  state_r <= `ANM_ST_L;
               else
                  state_r <= `ANM_ST_M;
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   end
endmodule // anm_strap_decode

`default_nettype wire

// File: logic/anm_resolve.v
// Priority resolution of common abilities after negotiation
`timescale 1ns/1ps
`default_nettype none
`include "anm_defines.vh"

module anm_resolve (
   input wire clk,
   input wire resetn,
   input wire [15:0] adv,
   input wire [15:0] lpa,
   input wire lpa_valid,
   output reg spd100_r,
   output reg fdx_r,
   output reg hit_r
);
   wire [3:0] common;

   // Partner abilities only count once negotiation has completed
   assign common = {adv[`ANM_ADV_100F] & lpa[`ANM_ADV_100F],
                    adv[`ANM_ADV_100H] & lpa[`ANM_ADV_100H],
                    adv[`ANM_ADV_10F] & lpa[`ANM_ADV_10F],
                    adv[`ANM_ADV_10H] & lpa[`ANM_ADV_10H]} & {4{lpa_valid}};

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         spd100_r <= 1'b0;
         fdx_r <= 1'b0;
         hit_r <= 1'b0;
      end else begin
         hit_r <= |common;
         if (common[3]) begin
            spd100_r <= 1'b1;
            fdx_r <= 1'b1;
         end else if (common[2]) begin
            spd100_r <= 1'b1;
            fdx_r <= 1'b0;
         end else if (common[1]) begin
            spd100_r <= 1'b0;
            fdx_r <= 1'b1;
         end else begin
            spd100_r <= 1'b0;
            fdx_r <= 1'b0;
         end
      end
   end
endmodule // anm_resolve

`default_nettype wire

// File: logic/anm_mode_ctrl.v
// Strap sampling, mode registers and operating mode selection
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "anm_defines.vh"

//Function
//- Each strap accepts low, high, mid, clock
//- Hardware reset loads status and advertisement from straps
//- Software reset restores defaults, ignores straps
//- Straps never touch control register contents
//- Software control write overrides strap negotiation choice
//- Advertisement register drives transmitted ability bursts
//- Mode status shows enable, duplex, speed in effect
//- Duplex, speed valid if disabled or complete
//- Pick best ability common to both sides
//- Priority 100 full, 100 half, 10 full, 10 half
//- Control register enables, disables, restarts negotiation
//- Bit 13 selects speed when negotiation off
//- Bit 8 selects duplex when negotiation off
//- Selection bits ignored while bit 12 set
//- Forced straps disable negotiation; mid-mid advertises all
//- Partner abilities valid only after negotiation completes
module anm_mode_ctrl #(
   parameter STRAP_WIN = `ANM_STRAP_WIN
) (
   input wire clk,
   input wire resetn,
   input wire [1:0] strap_pin_low_cmp,
   input wire [1:0] strap_pin_high_cmp,
   input wire an_complete,
   input wire link_up,
   input wire [15:0] partner_ability,
   output wire [15:0] adv_ability,
   output wire an_enable,
   output reg an_restart_r,
   output reg mode_spd100_r,
   output reg mode_fdx_r,
   output reg mode_valid_r,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ---------------------------------------------------------------
   // Strap comparator synchronisers
   // ---------------------------------------------------------------
   reg [3:0] cmp_s1_r;
   reg [3:0] cmp_s2_r;
   wire [3:0] cmp_raw;
   wire [1:0] st_low;
   wire [1:0] st_high;
   wire [1:0] dec_done;
   reg start_r;
   reg cap_done_r;
   reg strap_anen_r;
   reg strap_spd10_r;
   reg strap_fdx_r;

   assign cmp_raw = {strap_pin_high_cmp, strap_pin_low_cmp};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cmp_s1_r[gi] <= 1'b0;
               cmp_s2_r[gi] <= 1'b0;
            end else begin
               cmp_s1_r[gi] <= cmp_raw[gi];
               cmp_s2_r[gi] <= cmp_s1_r[gi];
            end
         end
      end
   endgenerate

   // Index 0,1 are the low pin comparators, 2,3 the high pin
   anm_strap_decode #(.WIN(STRAP_WIN)) u_dec_low (
      .clk(clk),
      .resetn(resetn),
      .start(start_r),
      .cmp_lo(cmp_s2_r[0]),
      .cmp_hi(cmp_s2_r[1]),
      .state_r(st_low),
      .done_r(dec_done[0])
   );

   anm_strap_decode #(.WIN(STRAP_WIN)) u_dec_high (
      .clk(clk),
      .resetn(resetn),
      .start(start_r),
      .cmp_lo(cmp_s2_r[2]),
      .cmp_hi(cmp_s2_r[3]),
      .state_r(st_high),
      .done_r(dec_done[1])
   );

   // ---------------------------------------------------------------
   // Strap table: {an_en, spd10, fdx, adv[8:0]}
   // ---------------------------------------------------------------
   function [11:0] strap_map;
      input [1:0] hi;
      input [1:0] lo;
      begin
         case ({hi, lo})
            {`ANM_ST_L, `ANM_ST_M}: strap_map = {3'b010, 9'h021};
            {`ANM_ST_H, `ANM_ST_M}: strap_map = {3'b011, 9'h041};
            {`ANM_ST_M, `ANM_ST_L}: strap_map = {3'b000, 9'h081};
            {`ANM_ST_M, `ANM_ST_H}: strap_map = {3'b001, 9'h101};
            {`ANM_ST_C, `ANM_ST_M}: strap_map = {3'b001, 9'h181};
            {`ANM_ST_M, `ANM_ST_C}: strap_map = {3'b001, 9'h141};
            {`ANM_ST_C, `ANM_ST_C}: strap_map = {3'b000, 9'h0a1};
            {`ANM_ST_M, `ANM_ST_M}: strap_map = {3'b100, 9'h1e1};
            {`ANM_ST_L, `ANM_ST_L}: strap_map = {3'b100, 9'h021};
            {`ANM_ST_L, `ANM_ST_H}: strap_map = {3'b100, 9'h041};
            {`ANM_ST_H, `ANM_ST_L}: strap_map = {3'b100, 9'h081};
            {`ANM_ST_H, `ANM_ST_H}: strap_map = {3'b100, 9'h101};
            {`ANM_ST_C, `ANM_ST_H}: strap_map = {3'b100, 9'h141};
            {`ANM_ST_C, `ANM_ST_L}: strap_map = {3'b100, 9'h0a1};
            {`ANM_ST_H, `ANM_ST_C}: strap_map = {3'b100, 9'h181};
            {`ANM_ST_L, `ANM_ST_C}: strap_map = {3'b100, 9'h061};
            default: strap_map = {3'b100, 9'h1e1};
         endcase
      end
   endfunction

   function [5:0] reg_idx;
      input [7:0] addr;
      begin
         // Bit 5 flags a mapped word
         if (addr[1:0] != 2'h0 || addr[7])
            reg_idx = 6'h00;
         else if (addr[6:2] == `ANM_IDX_BMC || addr[6:2] == `ANM_IDX_BMS ||
                  addr[6:2] == `ANM_IDX_ADV || addr[6:2] == `ANM_IDX_LPA ||
                  addr[6:2] == `ANM_IDX_PMS)
            reg_idx = {1'b1, addr[6:2]};
         else
            reg_idx = 6'h00;
      end
   endfunction

   wire [11:0] strap_cfg;
   assign strap_cfg = strap_map(st_high, st_low);

   // ---------------------------------------------------------------
   // Registers and bus slave
   // ---------------------------------------------------------------
   reg [15:0] bmc_r;
   reg [15:0] adv_r;
   reg ovr_r;
   reg aw_hold_r;
   reg w_hold_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   wire [5:0] wr_idx;
   wire [5:0] rd_idx;
   wire do_write;
   wire [15:0] wmask;
   wire [15:0] bmc_wr;
   wire [15:0] adv_wr;
   wire an_en_eff;
   wire frc_spd100;
   wire frc_fdx;
   wire res_spd100;
   wire res_fdx;
   wire res_hit;
   wire [15:0] bms_val;
   wire [15:0] pms_val;
   reg [15:0] rd_val;

   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign wr_idx = reg_idx(awaddr_r);
   assign rd_idx = reg_idx(s_axi_araddr);
   assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign bmc_wr = ((bmc_r & ~wmask) | (wdata_r[15:0] & wmask)) & `ANM_BMC_WMASK;
   assign adv_wr = (adv_r & ~wmask) | (wdata_r[15:0] & wmask);

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         start_r <= 1'b0;
         cap_done_r <= 1'b0;
         strap_anen_r <= 1'b0;
         strap_spd10_r <= 1'b0;
         strap_fdx_r <= 1'b0;
         bmc_r <= `ANM_BMC_RST_VAL;
         adv_r <= `ANM_ADV_DEF;
         ovr_r <= 1'b0;
         an_restart_r <= 1'b0;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ANM_RESP_OKAY;
      end else begin
         start_r <= 1'b1;
         an_restart_r <= 1'b0;
         // One-time capture after hardware reset release
         if (&dec_done && !cap_done_r) begin
            cap_done_r <= 1'b1;
            strap_anen_r <= strap_cfg[11];
            strap_spd10_r <= strap_cfg[10];
            strap_fdx_r <= strap_cfg[9];
            adv_r <= {adv_r[15:9], strap_cfg[8:0]};
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_idx[5] ? `ANM_RESP_OKAY : `ANM_RESP_SLVERR;
            if (wr_idx == {1'b1, `ANM_IDX_BMC}) begin
               if (wstrb_r[1] && wdata_r[`ANM_BMC_SWRST]) begin
                  bmc_r <= `ANM_BMC_RST_VAL;
                  adv_r <= `ANM_ADV_DEF;
                  ovr_r <= 1'b1;
                  an_restart_r <= 1'b1;
               end else begin
                  // Restart and reset bits self-clear
                  bmc_r <= bmc_wr & ~(16'h0001 << `ANM_BMC_RESTART);
                  ovr_r <= 1'b1;
                  if (bmc_wr[`ANM_BMC_RESTART] ||
                      (bmc_wr[`ANM_BMC_ANEN] && !an_en_eff))
                     an_restart_r <= 1'b1;
               end
            end else if (wr_idx == {1'b1, `ANM_IDX_ADV}) begin
               adv_r <= adv_wr;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Operating mode selection
   // ---------------------------------------------------------------
   assign an_en_eff = ovr_r ? bmc_r[`ANM_BMC_ANEN] : strap_anen_r;
   assign frc_spd100 = ovr_r ? bmc_r[`ANM_BMC_SPD100] : !strap_spd10_r;
   assign frc_fdx = ovr_r ? bmc_r[`ANM_BMC_FDX] : strap_fdx_r;
   assign an_enable = an_en_eff && cap_done_r;
   assign adv_ability = adv_r;

   anm_resolve u_res (
      .clk(clk),
      .resetn(resetn),
      .adv(adv_r),
      .lpa(partner_ability),
      .lpa_valid(an_complete),
      .spd100_r(res_spd100),
      .fdx_r(res_fdx),
      .hit_r(res_hit)
   );

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_spd100_r <= 1'b0;
         mode_fdx_r <= 1'b0;
         mode_valid_r <= 1'b0;
      end else if (!an_en_eff) begin
         mode_spd100_r <= frc_spd100;
         mode_fdx_r <= frc_fdx;
         mode_valid_r <= cap_done_r;
      end else begin
         // Forced selection bits take no part here
         mode_spd100_r <= res_spd100;
         mode_fdx_r <= res_fdx;
         mode_valid_r <= an_complete && res_hit;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   assign bms_val = `ANM_BMS_FIXED | ({15'h0000, an_complete} << `ANM_BMS_ANDONE) |
                    ({15'h0000, link_up} << `ANM_BMS_LINK);
   assign pms_val = ({15'h0000, an_en_eff} << `ANM_PMS_ANEN) |
                    ({15'h0000, mode_fdx_r} << `ANM_PMS_FDX) |
                    ({15'h0000, !mode_spd100_r} << `ANM_PMS_SPD10);

   always @* begin
      case (rd_idx)
         {1'b1, `ANM_IDX_BMC}: rd_val = bmc_r;
         {1'b1, `ANM_IDX_BMS}: rd_val = bms_val;
         {1'b1, `ANM_IDX_ADV}: rd_val = adv_r;
         {1'b1, `ANM_IDX_LPA}: rd_val = partner_ability;
         {1'b1, `ANM_IDX_PMS}: rd_val = pms_val;
         default: rd_val = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ANM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_val};
         s_axi_rresp <= rd_idx[5] ? `ANM_RESP_OKAY : `ANM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // anm_mode_ctrl

`default_nettype wire

// File: tb/anm_mode_ctrl_checker.sv
// Concurrent checks on the mode control block ports
`timescale 1ns/1ps
`default_nettype none
module anm_mode_ctrl_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic an_complete,
   input wire logic [15:0] partner_ability,
   input wire logic [15:0] adv_ability,
   input wire logic an_enable,
   input wire logic an_restart_r,
   input wire logic mode_spd100_r,
   input wire logic mode_fdx_r,
   input wire logic mode_valid_r,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   wire [15:0] com = adv_ability & partner_ability;
   wire settled = an_enable && an_complete && (com[8:5] != 4'h0);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   restart_pulse_a: assert property (an_restart_r |=> !an_restart_r)
      else $error("restart pulse too long");
   early_mode_a: assert property ((an_enable && !an_complete) [*3] |-> !mode_valid_r)
      else $error("mode valid before completion");
   speed_pick_a: assert property (($stable(com) && settled) [*3] |->
      mode_valid_r && mode_spd100_r == (com[8] | com[7])) else $error("wrong speed picked");
   duplex_pick_a: assert property (($stable(com) && settled) [*3] |->
      mode_fdx_r == (com[8] | (!com[7] & com[6]))) else $error("wrong duplex picked");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (an_restart_r);
   cover property (settled && mode_valid_r);
endmodule // anm_mode_ctrl_checker
bind anm_mode_ctrl anm_mode_ctrl_checker u_chk (.clk, .resetn, .an_complete, .partner_ability,
   .adv_ability, .an_enable, .an_restart_r, .mode_spd100_r, .mode_fdx_r, .mode_valid_r,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: tb/anm_link_partner.sv
// Remote link partner that completes negotiation after a delay
`timescale 1ns/1ps
`default_nettype none
module anm_link_partner (
   input wire logic clk,
   input wire logic resetn,
   input wire logic an_enable,
   input wire logic an_restart,
   input wire logic go,
   input wire logic slow,
   input wire logic [15:0] ability,
   output logic an_complete,
   output logic link_up,
   output logic [15:0] partner_ability
);
   logic [7:0] cnt_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 8'h00;
         an_complete <= 1'b0;
         link_up <= 1'b0;
         partner_ability <= 16'ha5a5;
      end else if (!go || !an_enable || an_restart) begin
         // No bursts heard: stale word churns
         cnt_r <= 8'h00;
         an_complete <= 1'b0;
         link_up <= 1'b0;
         partner_ability <= ~partner_ability;
      end else if (cnt_r == (slow ? 8'h28 : 8'h03)) begin
         an_complete <= 1'b1;
         link_up <= 1'b1;
         partner_ability <= ability;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule // anm_link_partner
`default_nettype wire

// File: tb/anm_mode_ctrl_tb.sv
// Register-level bench for the mode control block
`timescale 1ns/1ps
`default_nettype none
`include "anm_defines.vh"
module anm_mode_ctrl_tb;
   localparam int WIN = 8;
   localparam logic [0:8][27:0] tab = {
      {`ANM_ST_L, `ANM_ST_M, 24'h021040}, {`ANM_ST_H, `ANM_ST_M, 24'h0410c0},
      {`ANM_ST_M, `ANM_ST_L, 24'h081000}, {`ANM_ST_M, `ANM_ST_H, 24'h101080},
      {`ANM_ST_C, `ANM_ST_M, 24'h181080}, {`ANM_ST_M, `ANM_ST_M, 24'h1e1400},
      {`ANM_ST_L, `ANM_ST_L, 24'h021400}, {`ANM_ST_H, `ANM_ST_C, 24'h181400},
      {`ANM_ST_C, `ANM_ST_C, 24'h0a1000}};
   localparam logic [0:4][47:0] ng = {48'h120001e101e1, 48'h120001e100e1,
      48'h1200006101e1, 48'h3300002101e1, 48'h1200014100e1};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] strap_pin_low_cmp = 2'b00, strap_pin_high_cmp = 2'b00;
   logic [1:0] st_lo = `ANM_ST_M, st_hi = `ANM_ST_M;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, go = 0, slow = 0;
   logic [15:0] lp_ab = 16'h0, m, c;
   wire an_complete, link_up, an_enable, an_restart_r, mode_spd100_r, mode_fdx_r, mode_valid_r;
   wire [15:0] partner_ability, adv_ability;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int n_errors = 0, comparisons = 0, cyc = 0, n_rst = 0;
   logic [31:0] rd;
   logic [1:0] rs;
   anm_mode_ctrl #(.STRAP_WIN(WIN)) u_dut (.clk, .resetn, .strap_pin_low_cmp,
      .strap_pin_high_cmp, .an_complete, .link_up, .partner_ability, .adv_ability, .an_enable,
      .an_restart_r, .mode_spd100_r, .mode_fdx_r, .mode_valid_r, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   anm_link_partner u_lp (.clk, .resetn, .an_enable, .an_restart(an_restart_r), .go, .slow,
      .ability(lp_ab), .an_complete, .link_up, .partner_ability);
   always #20 clk = ~clk;
   function automatic logic [1:0] cmp(input logic [1:0] st, input logic ph);
      case (st)
         `ANM_ST_L: return 2'b00;
         `ANM_ST_M: return 2'b10;
         `ANM_ST_H: return 2'b11;
         default: return {ph, ph};
      endcase
   endfunction
   // ---
   // Straps, clock strap at a quarter of clk, timeout
   // ---
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (an_restart_r) n_rst <= n_rst + 1;
      strap_pin_low_cmp <= cmp(st_lo, cyc[1]);
      strap_pin_high_cmp <= cmp(st_hi, cyc[1]);
      if (cyc == 30000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic boot(input logic [1:0] h, input logic [1:0] l);
      st_hi <= h;
      st_lo <= l;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (WIN + 8) @(posedge clk);
   endtask
   task automatic conclude;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ---
   // Tests
   // ---
   initial begin
      for (int i = 0; i < 9; i++) begin
         boot(tab[i][27:26], tab[i][25:24]);
         rdr(8'h10);
         chk("strap adv", tab[i][23:12], rd);
         chk("adv port", tab[i][23:12], adv_ability);
         rdr(8'h64);
         m = tab[i][10] ? 16'h0400 : 16'h04c0;
         chk("strap status", tab[i][11:0] & m, rd & m);
         chk("enable pin", tab[i][10], an_enable);
         if (!tab[i][10]) chk("forced pins", {1'b1, ~tab[i][6], tab[i][7]},
            {mode_valid_r, mode_spd100_r, mode_fdx_r});
         rdr(8'h00);
         chk("ctrl untouched", 16'h3000, rd);
      end
      st_hi <= `ANM_ST_L;
      st_lo <= `ANM_ST_L;
      repeat (20) @(posedge clk);
      rdr(8'h10);
      chk("held adv", 16'h00a1, rd);
      $display("test straps done");
      boot(`ANM_ST_M, `ANM_ST_M);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {2'b00, i[1], 4'h0, i[0], 8'h00});
         rdr(8'h64);
         chk("sw status", {i[0], ~i[1], 6'h00}, rd);
         chk("sw pins", {1'b1, i[1], i[0]}, {mode_valid_r, mode_spd100_r, mode_fdx_r});
      end
      wr(8'h00, 16'h6d00);
      rdr(8'h00);
      chk("ctrl fields", 16'h2100, rd);
      $display("test forced done");
      for (int i = 0; i < 5; i++) begin
         go <= 1'b0;
         slow <= (i == 4);
         lp_ab <= ng[i][15:0];
         wr(8'h10, ng[i][31:16]);
         wr(8'h00, ng[i][47:32]);
         repeat (3) @(posedge clk);
         chk("valid early", 1'b0, mode_valid_r);
         go <= 1'b1;
         c = ng[i][31:16] & ng[i][15:0];
         while (!an_complete) @(posedge clk);
         repeat (4) @(posedge clk);
         chk("pick pins", {1'b1, c[8] | c[7], c[8] | (~c[7] & c[6])},
            {mode_valid_r, mode_spd100_r, mode_fdx_r});
         rdr(8'h64);
         chk("pick status", {1'b1, 2'b00, c[8] | (~c[7] & c[6]), ~(c[8] | c[7]), 6'h00},
            rd);
      end
      rdr(8'h04);
      chk("basic status", 16'h782d, rd);
      rdr(8'h14);
      chk("partner reg", 16'h00e1, rd);
      $display("test negotiation done");
      wr(8'h10, 16'h0021);
      wr(8'h00, 16'h0000);
      st_hi <= `ANM_ST_L;
      wr(8'h00, 16'h8000);
      rdr(8'h00);
      chk("soft ctrl", 16'h3000, rd);
      rdr(8'h10);
      chk("soft adv", 16'h01e1, rd);
      rdr(8'h64);
      chk("soft enable", 16'h0400, rd & 16'h0400);
      chk("restart count", 32'd6, n_rst);
      $display("test soft reset done");
      rdr(8'h08);
      chk("unmapped rdata", 32'h0, rd);
      chk("unmapped rresp", `ANM_RESP_SLVERR, rs);
      wr(8'h08, 16'h1234);
      chk("unmapped bresp", `ANM_RESP_SLVERR, rs);
      $display("test bus done");
      conclude();
   end
endmodule // anm_mode_ctrl_tb
`default_nettype wire
